// *** rtl/ars_defines.vh ***
// constants of the multilane serial result readout controller
//
// Behaviour
// R1: results are 12-bit words, MSB first
// R2: single-ended: use lanes 1-8, 1/3/5/7, 1/5, 1
// R3: each lane rotates all eight channels repeatedly
// R4: lane one starts at channel 1, wraps
// R5: other lanes start at their own channel
// R6: four lanes: two results each, 32 bits
// R7: two lanes: four results each, 64 bits
// R8: one lane: eight results, 128 bits
// R9: differential: pairs A-D, A and C, A
// R10: pair base channels 1, 3, 5, 7
// R11: pair A starts at channel 1, wraps
// R12: pairs A, C: four results, 64 bits
// R13: pair A alone: eight results, 128 bits
// R14: fewer lanes lowers the conversion rate
// R15: clock cycles 128/lanes SDR, 64/lanes DDR
// R16: period covers strobe, conversion and readout time
// R17: SDR: falling clock edge shifts next bit
// R18: DDR: both clock edges shift bits
// R19: data rate select low SDR, high DDR
// R20: strobe rise samples, fall starts conversion
// R21: restart counter per conversion, channel base plus k
`ifndef ARS_DEFINES_VH
`define ARS_DEFINES_VH

// ============================================================
// timing
`define ARS_CLK_PERIOD_NS 10
`define ARS_MIN_STROBE_NS 30
`define ARS_MAX_CONVERT_NS 500
// strobe and conversion cycle counts are the ns figures above over the clock period, rounded up,
// sized so that they meet the parameters without silent truncation
`define ARS_STROBE_CYCLES 10'h003
`define ARS_CONVERT_CYCLES 10'h032
`define ARS_SCK_HALF_CYCLES 8'h08
`define ARS_ECHO_TIMEOUT 8'h40

// ============================================================
// frame layout
`define ARS_BITS_ONE_LANE 8'h80
`define ARS_SLOT_BITS 16
`define ARS_RESULT_BITS 12
`define ARS_CHAN_BITS 3

// ============================================================
// lane count encoding
`define ARS_LANES_1 2'h0
`define ARS_LANES_2 2'h1
`define ARS_LANES_4 2'h2
`define ARS_LANES_8 2'h3

`endif

// *** rtl/ars_sync2.v ***
// two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/100ps
module ars_sync2 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire clock,
    input wire reset_n,
    // asynchronous side
    input wire [WIDTH-1:0] async_in,
    // synchronised side
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// *** rtl/ars_skid2.v ***
// two-entry buffer with registered head, valid and ready on both sides
`timescale 1ns/100ps
module ars_skid2 #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire clock,
    input wire reset_n,
    // filling side
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output wire in_ready,
    // draining side
    output reg out_valid,
    output reg [WIDTH-1:0] out_data,
    input wire out_ready
);

    reg [WIDTH-1:0] tail;
    reg tail_valid;
    wire push;
    wire pop;

    // ready depends only on a flop, so no path from out_ready to in_ready
    assign in_ready = ~tail_valid;
    assign push = in_valid & ~tail_valid;
    assign pop = out_valid & out_ready;

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
            tail <= {WIDTH{1'b0}};
            tail_valid <= 1'b0;
        end
        else if (pop && push)
        begin
            out_data <= in_data;
        end
        else if (pop)
        begin
            if (tail_valid)
            begin
                out_data <= tail;
                tail_valid <= 1'b0;
            end
            else
            begin
                out_valid <= 1'b0;
            end
        end
        else if (push)
        begin
            if (!out_valid)
            begin
                out_data <= in_data;
                out_valid <= 1'b1;
            end
            else
            begin
                tail <= in_data;
                tail_valid <= 1'b1;
            end
        end
    end

endmodule

// *** rtl/ars_readout.v ***
// host controller: strobes the converter, clocks it and collects lane results
`timescale 1ns/100ps
`include "ars_defines.vh"
module ars_readout #(
    parameter [9:0] STROBE_CYCLES = `ARS_STROBE_CYCLES,
    parameter [9:0] CONVERT_CYCLES = `ARS_CONVERT_CYCLES,
    parameter [7:0] SCK_HALF = `ARS_SCK_HALF_CYCLES
) (
    // clock and reset
    input wire clock,
    input wire reset_n,
    // configuration, same clock domain, taken while idle
    input wire [1:0] cfg_lanes,
    input wire cfg_diff,
    input wire cfg_ddr,
    // conversion request
    input wire start,
    input wire run,
    // converter pins
    output reg convert_strobe_n,
    output reg serial_clock,
    output reg data_rate_select,
    input wire echo_clock_out,
    input wire [7:0] single_ended_lane,
    input wire diff_pair_a_out,
    input wire diff_pair_b_out,
    input wire diff_pair_c_out,
    input wire diff_pair_d_out,
    // result stream
    output wire result_valid,
    output wire [`ARS_CHAN_BITS-1:0] result_channel,
    output wire [`ARS_RESULT_BITS-1:0] result_data,
    input wire result_ready,
    // status
    output reg busy,
    output reg conv_done,
    output reg echo_error
);

    // ============================================================
    // states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_STROBE = 3'h1;
    localparam [2:0] ST_CONVERT = 3'h2;
    localparam [2:0] ST_READ = 3'h3;
    localparam [2:0] ST_FINISH = 3'h4;
    localparam [9:0] STROBE_LAST = STROBE_CYCLES - 10'h1;
    localparam [9:0] CONVERT_LAST = CONVERT_CYCLES - 10'h1;
    localparam [7:0] HALF_LAST = SCK_HALF - 8'h1;
    localparam FW = `ARS_CHAN_BITS + `ARS_RESULT_BITS;

    reg [2:0] state;
    reg [9:0] timer;
    reg [7:0] div_cnt;
    reg [8:0] toggles;
    reg [8:0] need_toggles;
    reg [7:0] bit_cnt;
    reg [7:0] need_bits;
    reg [7:0] watchdog;
    reg [1:0] lsel;
    reg diff;
    reg ddr;

    // ============================================================
    // pin synchronisers
    wire [12:0] pins_raw;
    wire [12:0] pins_sync;
    reg [12:0] pins_prev;

    assign pins_raw = {echo_clock_out, diff_pair_d_out, diff_pair_c_out, diff_pair_b_out,
                       diff_pair_a_out, single_ended_lane};

    ars_sync2 #(
        .WIDTH(13)
    ) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            pins_prev <= 13'h0000;
        else
            pins_prev <= pins_sync;
    end

    wire echo_now = pins_sync[12];
    wire echo_was = pins_prev[12];
    wire [7:0] se_before = pins_prev[7:0];
    wire [3:0] pair_before = pins_prev[11:8];
    // SDR data moves on falling edges, so the rising echo edge is the capture point;
    // in DDR every echo edge counts
    wire cap_edge = ddr ? (echo_now ^ echo_was) : (echo_now & ~echo_was); // [R17] [R18]
    wire capturing = ((state == ST_READ) || (state == ST_FINISH)) && (bit_cnt != need_bits);
    wire cap = capturing && cap_edge;

    // ============================================================
    // lane selection
    // lane k of L used lanes is physical lane k*8/L; pair k is pair k*4/L
    reg [3:0] se_stride;
    reg [3:0] pair_stride;
    reg [7:0] cap_bits;
    integer k;

    always @*
    begin
        case (lsel)
            `ARS_LANES_1: se_stride = 4'h8; // [R8]
            `ARS_LANES_2: se_stride = 4'h4; // [R2] [R7]
            `ARS_LANES_4: se_stride = 4'h2; // [R6]
            default: se_stride = 4'h1;
        endcase
        case (lsel)
            `ARS_LANES_1: pair_stride = 4'h4; // [R9] [R13]
            `ARS_LANES_2: pair_stride = 4'h2; // [R12]
            default: pair_stride = 4'h1;
        endcase
        cap_bits = 8'h00;
        // the value held just before the edge is the bit that edge retires
        for (k = 0; k < 8; k = k + 1)
        begin
            if (diff)
                cap_bits[k] = pair_before[(k * pair_stride) % 4];
            else
                cap_bits[k] = se_before[(k * se_stride) % 8];
        end
    end

    // ============================================================
    // per-lane shift registers and slot hold
    reg [`ARS_SLOT_BITS-1:0] shift [0:7];
    reg [`ARS_SLOT_BITS-1:0] hold [0:7];
    reg [2:0] hold_slot;
    reg hold_pend;
    reg [2:0] drain_idx;
    wire slot_end = (bit_cnt[3:0] == 4'hf);
    wire fifo_ready;
    wire pop_word = hold_pend && fifo_ready;
    wire [2:0] lane_last = (3'h1 << lsel) - 3'h1;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : gen_lane
            always @(posedge clock or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    shift[g] <= {`ARS_SLOT_BITS{1'b0}};
                    hold[g] <= {`ARS_SLOT_BITS{1'b0}};
                end
                else if (cap)
                begin
                    shift[g] <= {shift[g][`ARS_SLOT_BITS-2:0], cap_bits[g]}; // [R1]
                    if (slot_end)
                        hold[g] <= {shift[g][`ARS_SLOT_BITS-2:0], cap_bits[g]};
                end
            end
        end
    endgenerate

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hold_pend <= 1'b0;
            hold_slot <= 3'h0;
            drain_idx <= 3'h0;
        end
        else if (cap && slot_end)
        begin
            // the slot index of this word; 16 capture edges apart, far beyond the drain
            hold_slot <= bit_cnt[6:4]; // [R3]
            hold_pend <= 1'b1;
            drain_idx <= 3'h0;
        end
        else if (pop_word)
        begin
            if (drain_idx == lane_last)
                hold_pend <= 1'b0;
            else
                drain_idx <= drain_idx + 3'h1;
        end
    end

    // ============================================================
    // channel tagging and output buffer
    // k-th result on a lane belongs to the lane's base channel plus k, mod 8
    wire [6:0] base_full = {4'h0, drain_idx} * {3'h0, se_stride};
    wire [2:0] word_chan = base_full[2:0] + hold_slot; // [R4] [R5] [R10] [R11] [R21]
    wire [`ARS_SLOT_BITS-1:0] word_slot = hold[drain_idx];
    wire [FW-1:0] word = {word_chan,
                          word_slot[`ARS_SLOT_BITS-1:`ARS_SLOT_BITS-`ARS_RESULT_BITS]};
    wire [FW-1:0] head;

    ars_skid2 #(
        .WIDTH(FW)
    ) u_buf (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(hold_pend),
        .in_data(word),
        .in_ready(fifo_ready),
        .out_valid(result_valid),
        .out_data(head),
        .out_ready(result_ready)
    );

    assign result_channel = head[FW-1:`ARS_RESULT_BITS];
    assign result_data = head[`ARS_RESULT_BITS-1:0];

    // ============================================================
    // sequencer
    // the clock pauses while a slot waits to drain, so a stalled receiver loses nothing
    wire sck_run = (state == ST_READ) && !hold_pend;
    wire [1:0] lsel_take = (cfg_diff && (cfg_lanes == `ARS_LANES_8)) ? `ARS_LANES_4 : cfg_lanes;
    wire [7:0] bits_take = `ARS_BITS_ONE_LANE >> lsel_take;
    wire frame_ok = (bit_cnt == need_bits) && !hold_pend;

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_IDLE;
            timer <= 10'h000;
            div_cnt <= 8'h00;
            toggles <= 9'h000;
            need_toggles <= 9'h000;
            bit_cnt <= 8'h00;
            need_bits <= 8'h00;
            watchdog <= 8'h00;
            lsel <= `ARS_LANES_8;
            diff <= 1'b0;
            ddr <= 1'b0;
            convert_strobe_n <= 1'b0;
            serial_clock <= 1'b0;
            data_rate_select <= 1'b0;
            busy <= 1'b0;
            conv_done <= 1'b0;
            echo_error <= 1'b0;
        end
        else
        begin
            conv_done <= 1'b0;
            if (cap)
                bit_cnt <= bit_cnt + 8'h01;
            case (state)
                ST_IDLE:
                begin
                    data_rate_select <= cfg_ddr; // [R19]
                    if (start || run)
                    begin
                        lsel <= lsel_take;
                        diff <= cfg_diff;
                        ddr <= cfg_ddr;
                        data_rate_select <= cfg_ddr;
                        need_bits <= bits_take; // [R15]
                        need_toggles <= cfg_ddr ? {1'b0, bits_take} : {bits_take, 1'b0};
                        convert_strobe_n <= 1'b1; // [R20]
                        timer <= 10'h000;
                        busy <= 1'b1;
                        echo_error <= 1'b0;
                        state <= ST_STROBE;
                    end
                end
                ST_STROBE:
                begin
                    bit_cnt <= 8'h00; // [R21]
                    timer <= timer + 10'h001;
                    if (timer == STROBE_LAST)
                    begin
                        // falling edge starts conversion; readout follows once CONVERT_CYCLES have passed
                        convert_strobe_n <= 1'b0; // [R20]
                        timer <= 10'h000;
                        state <= ST_CONVERT;
                    end
                end
                ST_CONVERT:
                begin
                    timer <= timer + 10'h001;
                    if (timer == CONVERT_LAST)
                    begin
                        div_cnt <= 8'h00;
                        toggles <= 9'h000;
                        state <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    if (sck_run)
                    begin
                        if (div_cnt == HALF_LAST)
                        begin
                            div_cnt <= 8'h00;
                            serial_clock <= ~serial_clock;
                            toggles <= toggles + 9'h001;
                            if (toggles + 9'h001 == need_toggles)
                            begin
                                watchdog <= 8'h00;
                                state <= ST_FINISH;
                            end
                        end
                        else
                        begin
                            div_cnt <= div_cnt + 8'h01;
                        end
                    end
                end
                ST_FINISH:
                begin
                    // the next strobe waits for this readout, so fewer lanes means
                    // a longer period and a lower conversion rate
                    watchdog <= watchdog + 8'h01;
                    if (frame_ok)
                    begin
                        conv_done <= 1'b1; // [R14] [R16]
                        busy <= 1'b0;
                        state <= ST_IDLE;
                    end
                    else if (watchdog == `ARS_ECHO_TIMEOUT && !hold_pend)
                    begin
                        // missing echo edges would otherwise hang the sequencer
                        echo_error <= 1'b1;
                        conv_done <= 1'b1;
                        busy <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// *** dv/ars_dev.sv ***
// behavioural converter: circular lane results and echo clock
`timescale 1ns/100ps
module ars_dev (
    // converter pins
    input wire convert_strobe_n,
    input wire serial_clock,
    input wire data_rate_select,
    output wire echo_clock_out,
    output wire [7:0] single_ended_lane,
    output wire diff_pair_a_out,
    output wire diff_pair_b_out,
    output wire diff_pair_c_out,
    output wire diff_pair_d_out,
    // fault injection
    input wire kill_echo
);
    // ============================================================
    // sample number and bit position
    reg [7:0] samp = 8'h00;
    reg [7:0] idx = 8'h00;
    always @(posedge convert_strobe_n)
        samp <= samp + 8'h01;
    always @(negedge convert_strobe_n)
        idx <= 8'h00;
    always @(serial_clock)
        if (!convert_strobe_n && (data_rate_select || !serial_clock))
            idx <= idx + 8'h01;
    // ============================================================
    // lane data, slot is result then four pad bits
    function bit_at(input [2:0] ch, input [3:0] pos, input [7:0] s);
        reg [15:0] w;
        begin
            w = {ch, 1'b1, s, 4'h0};
            bit_at = w[4'hf - pos];
        end
    endfunction
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : se
            assign #2 single_ended_lane[g] = bit_at(3'(g) + idx[6:4], idx[3:0], samp);
        end
    endgenerate
    assign #2 diff_pair_a_out = bit_at(idx[6:4], idx[3:0], samp);
    assign #2 diff_pair_b_out = bit_at(3'h2 + idx[6:4], idx[3:0], samp);
    assign #2 diff_pair_c_out = bit_at(3'h4 + idx[6:4], idx[3:0], samp);
    assign #2 diff_pair_d_out = bit_at(3'h6 + idx[6:4], idx[3:0], samp);
    // echo shares the data delay so the pair stays phase aligned
    assign #2 echo_clock_out = serial_clock & !kill_echo;
endmodule

// *** dv/ars_readout_properties.sv ***
// concurrent checks on the readout controller ports
`timescale 1ns/100ps
module ars_readout_props #(
    parameter [9:0] STROBE_CYCLES = 10'h003,
    parameter [9:0] CONVERT_CYCLES = 10'h032,
    parameter [7:0] SCK_HALF = 8'h08
) (
    // clock and reset
    input wire clock,
    input wire reset_n,
    // configuration
    input wire [1:0] cfg_lanes,
    input wire cfg_diff,
    input wire cfg_ddr,
    // converter pins
    input wire convert_strobe_n,
    input wire serial_clock,
    input wire data_rate_select,
    // result stream and status
    input wire result_valid,
    input wire [2:0] result_channel,
    input wire [11:0] result_data,
    input wire result_ready,
    input wire busy,
    input wire conv_done,
    input wire echo_error
);
    // ============================================================
    // strobe width and clock toggle counters
    reg [9:0] hi_cnt;
    reg [8:0] tog;
    reg [8:0] tog_exp;
    reg prev_strobe;
    reg prev_sck;
    wire [1:0] lg = (cfg_diff && cfg_lanes == 2'h3) ? 2'h2 : cfg_lanes;
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hi_cnt <= 10'h000;
            tog <= 9'h000;
            tog_exp <= 9'h000;
            prev_strobe <= 1'b0;
            prev_sck <= 1'b0;
        end
        else
        begin
            prev_strobe <= convert_strobe_n;
            prev_sck <= serial_clock;
            hi_cnt <= convert_strobe_n ? hi_cnt + 10'h001 : 10'h000;
            if (convert_strobe_n && !prev_strobe)
            begin
                tog <= 9'h000;
                tog_exp <= (data_rate_select ? 9'h080 : 9'h100) >> lg;
            end
            else if (serial_clock != prev_sck)
                tog <= tog + 9'h001;
        end
    end
    // ============================================================
    // assertions and covers
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_strobe_width: assert property ($fell(convert_strobe_n) |-> hi_cnt == STROBE_CYCLES)
        else $error("strobe high time wrong");
    a_rise_busy: assert property ($rose(convert_strobe_n) |-> busy)
        else $error("strobe rose while not busy");
    a_idle_clock: assert property (convert_strobe_n |-> !serial_clock)
        else $error("clock moved during sampling");
    a_rate_taken: assert property ($rose(convert_strobe_n) |-> data_rate_select == cfg_ddr)
        else $error("rate select not taken");
    a_rate_static: assert property (busy ##1 busy |-> $stable(data_rate_select))
        else $error("rate select moved while busy");
    a_clock_count: assert property (conv_done |-> tog == tog_exp)
        else $error("clock toggle count wrong");
    a_valid_hold: assert property (result_valid && !result_ready |=>
        result_valid && $stable(result_channel) && $stable(result_data))
        else $error("stalled word changed");
    a_strobe_idle: assert property ($rose(convert_strobe_n) |-> !$past(busy))
        else $error("strobe rose before the readout ended");
    a_clock_quiet: assert property (!busy |-> !serial_clock)
        else $error("clock moved while idle");
    c_echo_fault: cover property (conv_done ##1 echo_error);
    c_stall: cover property (result_valid && !result_ready);
    c_ddr_done: cover property (conv_done && data_rate_select);
endmodule
bind ars_readout ars_readout_props #(.STROBE_CYCLES(STROBE_CYCLES),
    .CONVERT_CYCLES(CONVERT_CYCLES), .SCK_HALF(SCK_HALF)) chk (.clock, .reset_n,
    .cfg_lanes, .cfg_diff, .cfg_ddr, .convert_strobe_n, .serial_clock, .data_rate_select,
    .result_valid, .result_channel, .result_data, .result_ready, .busy, .conv_done,
    .echo_error);

// *** dv/test_ars_readout.sv ***
// self-checking bench for the readout controller
`timescale 1ns/100ps
module test_ars_readout;
    // ============================================================
    // stimulus and observed signals
    reg clock = 1'b0;
    reg reset_n = 1'b0;
    reg [1:0] cfg_lanes = 2'h0;
    reg cfg_diff = 1'b0;
    reg cfg_ddr = 1'b0;
    reg start = 1'b0;
    reg run = 1'b0;
    reg result_ready = 1'b0;
    reg kill = 1'b0;
    reg slow = 1'b0;
    wire convert_strobe_n, serial_clock, data_rate_select, echo_clock_out;
    wire [7:0] se_lane;
    wire pa, pb, pc, pd, result_valid, busy, conv_done, echo_error;
    wire [2:0] result_channel;
    wire [11:0] result_data;
    integer failures = 0;
    integer cmp_count = 0;
    integer done_cnt = 0;
    integer cyc = 0;
    integer i;
    integer t;
    reg [7:0] n = 8'h00;
    // row: lanes used, then diff, ddr, lane code
    localparam [95:0] ROWS = 96'h83_42_21_10_87_46_25_14_4b_4e_2d_1c;
    always #5 clock = ~clock;
    ars_readout #(.STROBE_CYCLES(10'h003), .CONVERT_CYCLES(10'h004), .SCK_HALF(8'h04)) uut (
        .clock(clock), .reset_n(reset_n), .cfg_lanes(cfg_lanes), .cfg_diff(cfg_diff),
        .cfg_ddr(cfg_ddr), .start(start), .run(run), .convert_strobe_n(convert_strobe_n),
        .serial_clock(serial_clock), .data_rate_select(data_rate_select),
        .echo_clock_out(echo_clock_out), .single_ended_lane(se_lane), .diff_pair_a_out(pa),
        .diff_pair_b_out(pb), .diff_pair_c_out(pc), .diff_pair_d_out(pd),
        .result_valid(result_valid), .result_channel(result_channel),
        .result_data(result_data), .result_ready(result_ready), .busy(busy),
        .conv_done(conv_done), .echo_error(echo_error));
    ars_dev dev (.convert_strobe_n(convert_strobe_n), .serial_clock(serial_clock),
        .data_rate_select(data_rate_select), .echo_clock_out(echo_clock_out),
        .single_ended_lane(se_lane), .diff_pair_a_out(pa), .diff_pair_b_out(pb),
        .diff_pair_c_out(pc), .diff_pair_d_out(pd), .kill_echo(kill));
    // slow mode takes one word in four so the buffer fills and the clock pauses
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        result_ready <= !slow || (cyc % 4 == 0);
        if (conv_done === 1'b1)
            done_cnt <= done_cnt + 1;
    end
    // ============================================================
    // tasks
    task check(input [31:0] got, input [31:0] exp, input [127:0] what);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp)
            begin
                failures = failures + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task go(input [3:0] cfg);
        begin
            @(posedge clock);
            cfg_diff <= cfg[3];
            cfg_ddr <= cfg[2];
            cfg_lanes <= cfg[1:0];
            @(posedge clock);
            start <= 1'b1;
            @(posedge clock);
            start <= 1'b0;
            n = n + 8'h01;
        end
    endtask
    task get_words(input [3:0] lanes, input [7:0] conv);
        integer w, k;
        reg [2:0] ch;
        begin
            for (w = 0; w < 8; w = w + 1)
            begin
                k = 0;
                @(negedge clock);
                while (!(result_valid === 1'b1 && result_ready === 1'b1) && k < 4000)
                begin
                    @(negedge clock);
                    k = k + 1;
                end
                check(k < 4000, 1, "word wait");
                ch = 3'((w % lanes) * (8 / lanes) + w / lanes);
                check(result_channel, ch, "channel");
                check(result_data, {ch, 1'b1, conv}, "data");
            end
        end
    endtask
    task wait_idle;
        integer k;
        begin
            k = 0;
            @(negedge clock);
            while (busy !== 1'b0 && k < 5000)
            begin
                @(negedge clock);
                k = k + 1;
            end
            repeat (2) @(negedge clock);
            check(k < 5000, 1, "idle wait");
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d failures %0d", cmp_count, failures);
            if (failures == 0 && cmp_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // ============================================================
    // main sequence
    initial
    begin
        repeat (8) @(posedge clock);
        check(convert_strobe_n | serial_clock | result_valid | busy, 0, "reset idle");
        reset_n <= 1'b1;
        for (i = 0; i < 12; i = i + 1)
        begin
            go(ROWS[91 - 8 * i -: 4]);
            get_words(ROWS[95 - 8 * i -: 4], n);
            wait_idle;
            check(done_cnt, i + 1, "done count");
        end
        // stalled receiver plus a start while busy
        slow = 1'b1;
        go(4'h3);
        repeat (20) @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        get_words(4'h8, n);
        wait_idle;
        slow = 1'b0;
        check(done_cnt, 13, "refused start");
        // back to back conversions
        @(posedge clock);
        run <= 1'b1;
        get_words(4'h8, n + 8'h01);
        for (t = 0; t < 400 && done_cnt < 14; t = t + 1)
            @(negedge clock);
        for (t = 0; t < 400 && busy !== 1'b1; t = t + 1)
            @(negedge clock);
        @(posedge clock);
        run <= 1'b0;
        get_words(4'h8, n + 8'h02);
        n = n + 8'h02;
        wait_idle;
        check(done_cnt, 15, "back to back");
        // missing echo ends in error, next start clears it
        @(posedge clock);
        kill <= 1'b1;
        go(4'h3);
        wait_idle;
        check(echo_error, 1, "echo error");
        kill <= 1'b0;
        go(4'h7);
        repeat (2) @(negedge clock);
        check(echo_error, 0, "error cleared");
        check(data_rate_select, 1, "rate select");
        get_words(4'h8, n);
        wait_idle;
        // reset in mid readout, then a clean frame
        go(4'h0);
        repeat (100) @(posedge clock);
        reset_n <= 1'b0;
        @(negedge clock);
        check(convert_strobe_n | serial_clock | busy | result_valid, 0, "mid reset");
        @(posedge clock);
        reset_n <= 1'b1;
        go(4'h0);
        get_words(4'h1, n);
        wait_idle;
        report_and_stop;
    end
    initial
    begin
        #400000;
        failures = failures + 1;
        report_and_stop;
    end
endmodule
